//--- pkg/adc_seq_pkg.sv
// Package with constants and types for the conversion sequencer
package adc_seq_pkg;
   // ==========================================================
   // Clock divider
   localparam logic [4:0] DIV_SLOW = 5'h1f; // divide by 32, count 0..31
   localparam logic [4:0] DIV_FAST = 5'h07; // divide by 8, count 0..7
   // ==========================================================
   // Resolution codes and input selection
   localparam logic [1:0] RES_6 = 2'h0;
   localparam logic [1:0] RES_8 = 2'h1;
   localparam logic [1:0] RES_10 = 2'h2;
   localparam logic [1:0] RES_12 = 2'h3;
   localparam logic [3:0] SEL_SUPPLY = 4'h8;
   localparam logic [3:0] SEL_LAST_PIN = 4'h7;
   // ==========================================================
   // Timing: single step takes N/2+3 cycles, continuous N/2+1
   localparam logic [3:0] SINGLE_EXTRA = 4'h3;
   localparam logic [3:0] CONT_EXTRA = 4'h1;
   // ==========================================================
   // Reset values
   localparam logic [1:0] RES_RESET = 2'h2; // 10-bit default
   localparam logic [11:0] MID_SCALE_12 = 12'h800;
   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_CONV} seq_state_e;
endpackage

//--- pkg/adc_result_if.sv
// Interface carrying a finished conversion into the result holder
interface adc_result_if;
   logic load;
   logic [11:0] code;
   logic uf;
   logic of;
   logic [1:0] res;
   logic [7:0] high;
   logic [7:0] low;
   modport seq (output load, output code, output uf, output of, output res,
      input high, input low);
   modport hold (input load, input code, input uf, input of, input res,
      output high, output low);
endinterface

//--- core/adc_result_hold.sv
// Result holder: places a finished code into the high and low result bytes
module adc_result_hold (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Result link
   adc_result_if.hold rif
);
   logic [7:0] high_ff;
   logic [7:0] low_ff;
   logic [7:0] nxt_high;
   logic [7:0] nxt_low;
   logic [11:0] lj;

   // Left justify the 12-bit code down to the selected width
   assign lj = rif.code;
   // 6 bit sits in high 5-0; 8 bit fills high; 10/12 extend into low
   always_comb begin
      nxt_high = lj[11:4];
      nxt_low = {lj[3:0], 1'b0, rif.uf, rif.of, rif.uf | rif.of};
      case (rif.res)
         adc_seq_pkg::RES_6: begin
            nxt_high = {2'h0, lj[11:6]};
            nxt_low = {4'h0, 1'b0, rif.uf, rif.of, rif.uf | rif.of};
         end
         adc_seq_pkg::RES_8: begin
            nxt_low = {4'h0, 1'b0, rif.uf, rif.of, rif.uf | rif.of};
         end
         adc_seq_pkg::RES_10: begin
            nxt_low = {lj[3:2], 2'h0, 1'b0, rif.uf, rif.of, rif.uf | rif.of};
         end
         default: begin
         end
      endcase
   end

   // Hold last result until the next completion, keeps reads coherent
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         high_ff <= 8'h00;
         low_ff <= 8'h00;
      end else if (rif.load) begin
         high_ff <= nxt_high;
         low_ff <= nxt_low;
      end
   end

   assign rif.high = high_ff;
   assign rif.low = low_ff;
endmodule

//--- core/adc_conversion_sequencer.sv
// Conversion sequencer: clock divider, trigger handling, timing and results
// Contract
// - End-of-conversion flag set whenever any conversion completes.
// - Reference select one with pins 0..7 uses external reference pin.
// - Reference select zero with external input uses internal bandgap.
// - Differential result is offset binary; zero difference gives mid code.
// - Up to eight bits only high byte; above eight extends into low.
// - Selector 8 samples supply third and forces internal bandgap.
// - Single conversion starts first converter edge after trigger returns high.
// - One-pulse completion when value becomes valid on result bus.
// - Single step takes N/2+3 converter-clock cycles.
// - New trigger during conversion aborts it and starts over.
// - Continuous run ignores trigger and converts repeatedly.
// - Continuous conversions follow every N/2+1 converter-clock cycles.
// - Input above reference saturates to maximum code.
// - Resolution codes 00..11 select 6, 8, 10, 12 bits, left justified; the 6-bit result sits right-aligned in high bits 5-0.
// - Converter clock is CPU clock over 32, or over 8 when fast.
// - Underflow gives zeros, overflow ones; range flag is their OR.
module adc_conversion_sequencer (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Control bits
   input wire logic conv_trigger_low_in,
   input wire logic continuous_run_in,
   input wire logic reference_select_in,
   input wire logic [3:0] input_select_in,
   input wire logic [1:0] resolution_select_in,
   input wire logic differential_mode_in,
   input wire logic fast_clock_select_in,
   // Interrupt flag access
   input wire logic flag_clear_in,
   input wire logic flag_set_in,
   // Analog side, sampled codes at full 12-bit scale
   input wire logic [11:0] analog_input_in,
   input wire logic [11:0] inverting_input_in,
   input wire logic [11:0] supply_third_in,
   input wire logic [11:0] ext_reference_pin_in,
   input wire logic [11:0] bandgap_in,
   // Analog controls
   output logic use_ext_reference_out,
   output logic [3:0] mux_select_out,
   // Results and status
   output logic converter_clock_out,
   output logic conv_done_out,
   output logic conv_irq_flag_out,
   output logic busy_out,
   output logic [7:0] result_high_out,
   output logic [7:0] result_low_out
);
   // ==========================================================
   // Converter clock divider, produces a one-cycle enable
   logic [4:0] div_ff;
   logic tick;
   logic [4:0] div_top;
   assign div_top = fast_clock_select_in ? adc_seq_pkg::DIV_FAST
      : adc_seq_pkg::DIV_SLOW;
   // Count past the top after a fast switch ticks at once: one short period
   assign tick = (div_ff >= div_top);
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) div_ff <= 5'h00;
      else div_ff <= tick ? 5'h00 : 5'(div_ff + 5'h01);
   end

   // ==========================================================
   // Trigger handling, sampled on converter ticks only
   logic trig_prev_ff;
   logic trig_rise;
   // Low seen on one tick then high on the next; shorter pulses are missed
   assign trig_rise = tick && conv_trigger_low_in && !trig_prev_ff;
   // Idle level of the trigger is high, so reset gives no false edge
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) trig_prev_ff <= 1'b1;
      else if (tick) trig_prev_ff <= conv_trigger_low_in;
   end

   // ==========================================================
   // Conversion length: N/2 plus extra cycles
   logic [3:0] half_n;
   logic [3:0] len;
   assign half_n = 4'(4'h3 + {2'h0, resolution_select_in}); // 3,4,5,6 = N/2
   assign len = continuous_run_in ? 4'(half_n + adc_seq_pkg::CONT_EXTRA)
      : 4'(half_n + adc_seq_pkg::SINGLE_EXTRA);

   // ==========================================================
   // Reference and input selection
   logic supply_sel;
   logic ext_ref;
   logic [11:0] ref_code;
   logic [11:0] sample;
   assign supply_sel = (input_select_in == adc_seq_pkg::SEL_SUPPLY);
   assign ext_ref = reference_select_in && !supply_sel
      && (input_select_in <= adc_seq_pkg::SEL_LAST_PIN);
   assign ref_code = ext_ref ? ext_reference_pin_in : bandgap_in;
   assign sample = supply_sel ? supply_third_in : analog_input_in;

   // ==========================================================
   // Code computation with clipping, result in 12-bit left justified form
   logic [12:0] num;
   logic [24:0] scaled;
   logic [12:0] raw;
   logic under;
   logic over;
   logic [11:0] mask;
   logic [11:0] code;
   // Differential: num = diff + ref/2, giving mid code at zero difference
   assign num = differential_mode_in && !supply_sel
      ? 13'({1'b0, sample} - {1'b0, inverting_input_in} + {2'h0, ref_code[11:1]})
      : {1'b0, sample};
   // Underflow only in differential mode, compared one bit wider so nothing wraps
   assign under = differential_mode_in && !supply_sel
      && (({1'b0, sample} + {2'h0, ref_code[11:1]}) < {1'b0, inverting_input_in});
   assign scaled = (ref_code == 12'h000) ? 25'h000_0000
      : 25'(({12'h000, num} << 12) / {13'h0000, ref_code});
   assign raw = 13'(scaled);
   assign over = !under && ((ref_code == 12'h000) || (scaled > 25'h000_0fff));
   // Mask clears the bits below the chosen resolution
   assign mask = 12'(12'hfff << (4'(4'h6) - {1'b0, half_n[2:0]} + 4'h6 - half_n));
   assign code = under ? 12'h000 : over ? mask : (raw[11:0] & mask);

   // ==========================================================
   // Sequencer state machine
   adc_seq_pkg::seq_state_e state_ff;
   adc_seq_pkg::seq_state_e nxt_state;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic done;
   logic start;
   assign start = continuous_run_in || trig_rise;
   // Counter runs 1..len ticks, so each conversion spans exactly len ticks
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      done = 1'b0;
      case (state_ff)
         adc_seq_pkg::ST_IDLE: begin
            if (tick && start) begin
               nxt_state = adc_seq_pkg::ST_CONV;
               nxt_cnt = 4'h1;
            end
         end
         adc_seq_pkg::ST_CONV: begin
            if (tick) begin
               if (!continuous_run_in && trig_rise) begin
                  nxt_cnt = 4'h1;
               end else if (cnt_ff >= len) begin
                  done = 1'b1;
                  nxt_cnt = 4'h1;
                  nxt_state = continuous_run_in ? adc_seq_pkg::ST_CONV
                     : adc_seq_pkg::ST_IDLE;
               end else begin
                  nxt_cnt = 4'(cnt_ff + 4'h1);
               end
            end
         end
         default: nxt_state = adc_seq_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff <= adc_seq_pkg::ST_IDLE;
         cnt_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // ==========================================================
   // Result holder
   adc_result_if rif ();
   assign rif.load = done;
   assign rif.code = code;
   assign rif.uf = under;
   assign rif.of = over;
   assign rif.res = resolution_select_in;
   adc_result_hold u_hold (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .rif(rif)
   );

   // ==========================================================
   // Registered outputs; set beats clear on the interrupt flag
   logic irq_ff;
   logic done_ff;
   logic cclk_ff;
   logic ext_ff;
   logic [3:0] mux_ff;
   logic busy_ff;
   // Busy follows the next state, so it is a flop yet not a cycle late
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_ff <= 1'b0;
         done_ff <= 1'b0;
         cclk_ff <= 1'b0;
         ext_ff <= 1'b0;
         mux_ff <= 4'h0;
         busy_ff <= 1'b0;
      end else begin
         irq_ff <= done || flag_set_in || (irq_ff && !flag_clear_in);
         done_ff <= done;
         cclk_ff <= (div_ff < {1'b0, div_top[4:1]}) ? 1'b1 : 1'b0;
         ext_ff <= ext_ref;
         mux_ff <= input_select_in;
         busy_ff <= (nxt_state == adc_seq_pkg::ST_CONV);
      end
   end

   // Every output below comes straight from a flop
   assign conv_irq_flag_out = irq_ff;
   assign conv_done_out = done_ff;
   assign converter_clock_out = cclk_ff;
   assign use_ext_reference_out = ext_ff;
   assign mux_select_out = mux_ff;
   assign busy_out = busy_ff;
   assign result_high_out = rif.high;
   assign result_low_out = rif.low;
endmodule

//--- dv/adc_seq_props.sv
// Concurrent checks on the conversion sequencer ports
module adc_seq_props (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Watched inputs
   input wire logic reference_select_in,
   input wire logic [3:0] input_select_in,
   input wire logic flag_clear_in,
   input wire logic flag_set_in,
   // Watched outputs
   input wire logic use_ext_reference_out,
   input wire logic [3:0] mux_select_out,
   input wire logic conv_done_out,
   input wire logic conv_irq_flag_out,
   input wire logic [7:0] result_high_out,
   input wire logic [7:0] result_low_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // ==========================================================
   // Reference choice needs two steady cycles, the output is registered
   sequence ext_pick;
      reference_select_in && input_select_in <= adc_seq_pkg::SEL_LAST_PIN;
   endsequence
   sequence int_pick;
      !reference_select_in;
   endsequence
   // ==========================================================
   // Completion, flag and result relations
   done_one_pulse_a: assert property (conv_done_out |=> !conv_done_out)
      else $error("done pulse too long");
   flag_on_done_a: assert property ($rose(conv_done_out) |-> ##[0:1] conv_irq_flag_out)
      else $error("flag missed completion");
   flag_sticky_a: assert property (conv_irq_flag_out && !flag_clear_in
      |=> conv_irq_flag_out)
      else $error("flag dropped without clear");
   flag_write_a: assert property (flag_set_in |=> conv_irq_flag_out)
      else $error("flag write ignored");
   result_hold_a: assert property (!conv_done_out
      |-> $stable({result_high_out, result_low_out}))
      else $error("result moved between completions");
   range_or_a: assert property (result_low_out[0]
      == (result_low_out[2] | result_low_out[1]))
      else $error("range flag wrong");
   ext_ref_a: assert property (ext_pick ##1 ext_pick |=> use_ext_reference_out)
      else $error("external reference not used");
   bandgap_pick_a: assert property (int_pick ##1 int_pick |=> !use_ext_reference_out)
      else $error("bandgap not used");
   supply_bandgap_a: assert property (mux_select_out == adc_seq_pkg::SEL_SUPPLY
      |-> !use_ext_reference_out)
      else $error("supply input with external reference");
endmodule

bind adc_conversion_sequencer adc_seq_props props_u (.clock_in(clock_in),
   .reset_n_in(reset_n_in), .reference_select_in(reference_select_in),
   .input_select_in(input_select_in), .flag_clear_in(flag_clear_in), .flag_set_in(flag_set_in),
   .use_ext_reference_out(use_ext_reference_out), .mux_select_out(mux_select_out),
   .conv_done_out(conv_done_out), .conv_irq_flag_out(conv_irq_flag_out),
   .result_high_out(result_high_out), .result_low_out(result_low_out));

//--- dv/analog_front_model.sv
// Behavioural analog front end: pin levels, supply divider and references
module analog_front_model (
   // Selection from the sequencer
   input wire logic [3:0] mux_select_in,
   // Levels set by the bench
   input wire logic [11:0] pin_level_in [8],
   input wire logic [11:0] supply_level_in,
   // Codes toward the sequencer
   output logic [11:0] analog_input_out,
   output logic [11:0] inverting_input_out,
   output logic [11:0] supply_third_out,
   output logic [11:0] ext_reference_pin_out,
   output logic [11:0] bandgap_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Non-pin selections read inverted, so a stale pin never looks right
   assign analog_input_out = mux_select_in[3] ? ~pin_level_in[0]
      : pin_level_in[mux_select_in[2:0]];
   assign inverting_input_out = pin_level_in[0];
   assign supply_third_out = supply_level_in / 12'h003;
   // Power-of-two references keep the expected codes exact
   assign ext_reference_pin_out = 12'h800;
   assign bandgap_out = 12'h400;
endmodule

//--- dv/adc_conversion_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
module adc_conversion_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Stimulus, partner wiring and observed outputs
   logic clock_in, reset_n_in, trig, run, rsel, dif, fast, fclr, fset, use_ext, done, flag;
   logic [3:0] sel, mux;
   logic [1:0] res;
   logic [11:0] pins [8];
   logic [11:0] supply, analog_input, ainv, sup3, eref, bgap;
   logic [7:0] hi, lo;
   logic busy, cclk, cprev;
   int k;
   int failures, n_checks, dones, c, d0;
   int seed = 32'hf9da;
   adc_conversion_sequencer dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .conv_trigger_low_in(trig), .continuous_run_in(run), .reference_select_in(rsel),
      .input_select_in(sel), .resolution_select_in(res), .differential_mode_in(dif),
      .fast_clock_select_in(fast), .flag_clear_in(fclr), .flag_set_in(fset),
      .analog_input_in(analog_input), .inverting_input_in(ainv), .supply_third_in(sup3),
      .ext_reference_pin_in(eref), .bandgap_in(bgap), .use_ext_reference_out(use_ext),
      .mux_select_out(mux), .converter_clock_out(cclk), .conv_done_out(done),
      .conv_irq_flag_out(flag), .busy_out(busy), .result_high_out(hi), .result_low_out(lo));
   analog_front_model front_u (.mux_select_in(mux), .pin_level_in(pins),
      .supply_level_in(supply), .analog_input_out(analog_input), .inverting_input_out(ainv),
      .supply_third_out(sup3), .ext_reference_pin_out(eref), .bandgap_out(bgap));
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) if (done === 1'b1) dones++;
   function automatic int div();
      return fast ? 8 : 32;
   endfunction
   // Expected bytes from the levels and settings; references are 2048 and 1024
   function automatic logic [15:0] model();
      int refv, num, n, code;
      logic uf, of;
      refv = (rsel && sel < 8) ? 2048 : 1024;
      num = (sel == 8) ? supply / 3 : pins[sel[2:0]];
      if (dif) num = num - pins[0] + refv / 2;
      uf = num < 0;
      code = uf ? 0 : num * 4096 / refv;
      of = code > 4095;
      if (of) code = 4095;
      n = 6 + 2 * res;
      code = code >> (12 - n);
      if (n == 6) return {8'(code), 5'h00, uf, of, uf | of};
      return {8'(code >> (n - 8)), 8'((code << (16 - n)) & 255) | {5'h00, uf, of, uf | of}};
   endfunction
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Waits for completion; in continuous run the trigger is thrashed meanwhile
   task wait_done();
      c = 0;
      k = 0;
      do begin
         @(negedge clock_in);
         c++;
         if (cclk && !cprev) k++;
         cprev = cclk;
         if (run) trig = 1'($random(seed));
      end while (done !== 1'b1 && c < 2000);
      if (c >= 2000) chk("done", 16'h0001, 16'h0000);
   endtask
   task pulse_trig(input int ticks);
      @(negedge clock_in);
      trig = 1'b0;
      repeat (ticks * div()) @(negedge clock_in);
      trig = 1'b1;
   endtask
   task time_chk();
      chk("time", 16'h0001, 16'(c >= (res + 6) * div() && c <= (res + 7) * div() + 2));
   endtask
   task flag_op(input logic clr, input logic st, input logic exp);
      @(negedge clock_in);
      fclr = clr;
      fset = st;
      @(negedge clock_in);
      fclr = 1'b0;
      fset = 1'b0;
      chk("flag", {15'h0000, exp}, {15'h0000, flag});
   endtask
   task report_and_stop();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clock_in);
      failures++;
      report_and_stop();
   end
   initial begin
      {reset_n_in, run, rsel, dif, fast, fclr, fset, sel, res, supply} = 25'h000_0000;
      trig = 1'b1;
      foreach (pins[k]) pins[k] = 12'h000;
      repeat (10) @(negedge clock_in);
      reset_n_in = 1'b1;
      for (int i = 0; i < 24; i++) begin
         foreach (pins[k]) pins[k] = 12'($random(seed));
         supply = 12'($random(seed));
         sel = 4'($unsigned($random(seed)) % 9);
         {rsel, fast, res} = 4'($random(seed));
         dif = sel inside {[1:7]} && 1'($random(seed));
         pulse_trig(2);
         wait_done();
         time_chk();
         chk("busy end", 16'h0000, {15'h0000, busy});
         chk("result", model(), {hi, lo});
         flag_op(1'b0, 1'b0, 1'b1);
         flag_op(1'b1, 1'b0, 1'b0);
         flag_op(1'b0, 1'b1, 1'b1);
         flag_op(1'b1, 1'b0, 1'b0);
      end
      $display("single test done");
      run = 1'b1;
      for (int f = 0; f < 8; f++) begin
         {fast, res} = 3'(f);
         repeat (3) wait_done();
         chk("cycle", 16'((res + 4) * div()), 16'(c));
         chk("clock ticks", 16'(res + 4), 16'(k));
         chk("cont result", model(), {hi, lo});
      end
      run = 1'b0;
      trig = 1'b1;
      repeat (400) @(negedge clock_in);
      $display("continuous test done");
      {fast, res} = 3'h6;
      d0 = dones;
      pulse_trig(6);
      chk("held low", 16'(d0), 16'(dones));
      chk("idle", 16'h0000, {15'h0000, busy});
      repeat (16) @(negedge clock_in);
      chk("busy", 16'h0001, {15'h0000, busy});
      pulse_trig(2);
      wait_done();
      time_chk();
      @(negedge clock_in);
      chk("restart", 16'(d0 + 1), 16'(dones));
      $display("restart test done");
      report_and_stop();
   end
endmodule
